// file: bcl_top.v
/*
 * Burst configuration, ECC status, external PLL side band and lane word
 * path, with an AXI4-Lite register slave and one level interrupt.
 * Assumes the lane words, memory ECC flags and scheduler run on core_clk;
 * burst codes and PLL signals come from other clocks and are synchronised.
 */
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`include "bcl_defines.vh"

module bcl_top (
    // Clock and reset
    input wire core_clk,
    input wire reset,
    // AXI4-Lite write address and data
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Interrupt
    output reg irq,
    // Burst codes
    input wire [3:0] burst_size_ceiling,
    input wire [3:0] burst_size_short,
    input wire [3:0] burst_size_floor,
    // Applied burst sizes to the scheduler
    output reg [9:0] ceil_bytes,
    output reg [9:0] seg_bytes,
    output reg enh_sched_en,
    // Memory ECC flags and status
    input wire [1:0] tx_mem_ecc,
    input wire [1:0] rx_mem_ecc,
    output reg [1:0] tx_ecc_status,
    output reg [1:0] rx_ecc_status,
    // External PLL
    input wire tx_pll_locked,
    input wire tx_pll_cal_busy,
    input wire [3:0] tx_serial_clk,
    input wire mac_pll_locked,
    output reg tx_pll_powerdown,
    // Transmit lane words
    input wire [267:0] tx_user_data,
    input wire [3:0] tx_user_valid,
    input wire tx_user_am,
    output reg [267:0] tx_pma_data,
    output reg [3:0] tx_data_valid,
    output reg alignment_marker_valid,
    // Receive lane words
    input wire [267:0] rx_pma_data,
    input wire [3:0] rx_data_valid,
    input wire xcoder_err,
    output reg [267:0] rx_user_data,
    output reg [3:0] rx_user_valid
);

    function [31:0] lane_mask;
        input [3:0] strb;
        begin
            lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        end
    endfunction

    // Synchronisers for inputs from other clocks.
    reg [11:0] code_s1_r;
    reg [11:0] code_s2_r;
    reg [2:0] pll_s1_r;
    reg [2:0] pll_s2_r;
    reg lock_d_r;
    reg [3:0] sclk_s1_r;
    reg [3:0] sclk_s2_r;
    reg [3:0] sclk_d_r;
    reg [3:0] sclk_alive_r;

    reg [3:0] ceil_code_r;
    reg [3:0] short_code_r;
    reg [3:0] floor_code_r;
    wire [9:0] dec_ceil;
    wire [9:0] dec_seg;
    wire dec_enh;
    wire dec_ok;
    wire cand_ok;

    reg [2:0] ctrl_r;
    reg [`BCL_NEV-1:0] irq_st_r;
    reg [`BCL_NEV-1:0] irq_st_nxt;
    reg [`BCL_NEV-1:0] irq_mask_r;
    reg [`BCL_NEV-1:0] ev;
    reg [1:0] tx_ecc_d_r;
    reg [1:0] rx_ecc_d_r;
    reg bad_cfg_d_r;

    reg aw_hold_r;
    reg [7:0] aw_addr_r;
    reg w_hold_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    wire wr_go;
    wire [31:0] wr_mask;
    wire wr_hit;
    reg [31:0] rd_val;
    reg rd_hit;

    wire tx_idle;
    wire tx_go;
    wire lock_now;

    assign lock_now = pll_s2_r[0];
    assign tx_idle = ~|tx_user_valid;
    assign tx_go = ctrl_r[`BCL_CTRL_TXEN] & ~ctrl_r[`BCL_CTRL_PD] & lock_now & ~pll_s2_r[1];
    assign wr_go = aw_hold_r & w_hold_r & ~s_axi_bvalid;
    assign wr_mask = lane_mask(w_strb_r);
    assign wr_hit = (aw_addr_r == `BCL_A_CTRL) || (aw_addr_r == `BCL_A_STAT)
        || (aw_addr_r == `BCL_A_SIZE) || (aw_addr_r == `BCL_A_IRQ)
        || (aw_addr_r == `BCL_A_MASK);

    // Decoder of the applied codes.
    bcl_burst_dec u_dec (
        .ceil_code(ceil_code_r),
        .short_code(short_code_r),
        .floor_code(floor_code_r),
        .ceil_bytes(dec_ceil),
        .seg_bytes(dec_seg),
        .enh_en(dec_enh),
        .cfg_ok(dec_ok)
    );

    // Decoder of the sampled codes, used to screen them before they apply.
    bcl_burst_dec u_cand (
        .ceil_code(code_s2_r[11:8]),
        .short_code(code_s2_r[7:4]),
        .floor_code(code_s2_r[3:0]),
        .ceil_bytes(),
        .seg_bytes(),
        .enh_en(),
        .cfg_ok(cand_ok)
    );

    // Two-flop synchronisers.
    always @(posedge core_clk) begin
        if (reset) begin
            code_s1_r <= 12'h000;
            code_s2_r <= 12'h000;
            pll_s1_r <= 3'h0;
            pll_s2_r <= 3'h0;
            lock_d_r <= 1'b0;
            sclk_s1_r <= 4'h0;
            sclk_s2_r <= 4'h0;
            sclk_d_r <= 4'h0;
        end else begin
            // The burst codes belong to another clock and are resampled here.
            code_s1_r <= {burst_size_ceiling, burst_size_short, burst_size_floor};
            code_s2_r <= code_s1_r;
            // Tied-low PLL inputs simply read as unlocked and idle.
            pll_s1_r <= {mac_pll_locked, tx_pll_cal_busy, tx_pll_locked};
            pll_s2_r <= pll_s1_r;
            lock_d_r <= lock_now;
            sclk_s1_r <= tx_serial_clk;
            sclk_s2_r <= sclk_s1_r;
            sclk_d_r <= sclk_s2_r;
        end
    end

    // Serial clock activity seen per lane; software clears it through CTRL.
    always @(posedge core_clk) begin
        if (reset) begin
            sclk_alive_r <= 4'h0;
        end else if (wr_go && aw_addr_r == `BCL_A_CTRL && w_strb_r[0]
            && w_data_r[`BCL_CTRL_CLR]) begin
            sclk_alive_r <= sclk_s2_r ^ sclk_d_r;
        end else begin
            sclk_alive_r <= sclk_alive_r | (sclk_s2_r ^ sclk_d_r);
        end
    end

    // Codes apply between bursts, no reset needed; a bad set never reaches the scheduler.
    always @(posedge core_clk) begin
        if (reset) begin
            ceil_code_r <= `BCL_RST_CEIL;
            short_code_r <= `BCL_RST_SHORT;
            floor_code_r <= `BCL_RST_FLOOR;
        end else if (tx_idle && cand_ok) begin
            ceil_code_r <= code_s2_r[11:8];
            short_code_r <= code_s2_r[7:4];
            floor_code_r <= code_s2_r[3:0];
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            ceil_bytes <= 10'h000;
            seg_bytes <= 10'h000;
            enh_sched_en <= 1'b0;
        end else begin
            ceil_bytes <= dec_ceil;
            seg_bytes <= dec_seg;
            enh_sched_en <= dec_enh;
        end
    end

    // ECC status levels follow the memory flags.
    always @(posedge core_clk) begin
        if (reset) begin
            tx_ecc_status <= 2'h0;
            rx_ecc_status <= 2'h0;
            tx_ecc_d_r <= 2'h0;
            rx_ecc_d_r <= 2'h0;
            bad_cfg_d_r <= 1'b1;
        end else begin
            tx_ecc_status <= tx_mem_ecc;
            rx_ecc_status <= rx_mem_ecc;
            tx_ecc_d_r <= tx_mem_ecc;
            rx_ecc_d_r <= rx_mem_ecc;
            bad_cfg_d_r <= ~cand_ok;
        end
    end

    // Interrupt events: rising edges of flags, lock loss, transcoder errors.
    always @* begin
        ev = {`BCL_NEV{1'b0}};
        ev[`BCL_EV_TXCOR] = tx_mem_ecc[1] & ~tx_ecc_d_r[1];
        ev[`BCL_EV_TXUNC] = tx_mem_ecc[0] & ~tx_ecc_d_r[0];
        ev[`BCL_EV_RXCOR] = rx_mem_ecc[1] & ~rx_ecc_d_r[1];
        ev[`BCL_EV_RXUNC] = rx_mem_ecc[0] & ~rx_ecc_d_r[0];
        ev[`BCL_EV_BADCFG] = ~cand_ok & ~bad_cfg_d_r;
        ev[`BCL_EV_UNLOCK] = lock_d_r & ~lock_now;
        ev[`BCL_EV_XCERR] = xcoder_err;
        irq_st_nxt = irq_st_r;
        if (wr_go && aw_addr_r == `BCL_A_IRQ) begin
            irq_st_nxt = irq_st_r & ~(w_data_r[`BCL_NEV-1:0] & wr_mask[`BCL_NEV-1:0]);
        end
        // A new event in the clearing cycle is kept.
        irq_st_nxt = irq_st_nxt | ev;
    end

    // Control, interrupt status, mask and the interrupt line.
    always @(posedge core_clk) begin
        if (reset) begin
            ctrl_r <= `BCL_RST_CTRL;
            irq_st_r <= {`BCL_NEV{1'b0}};
            irq_mask_r <= {`BCL_NEV{1'b0}};
            irq <= 1'b0;
        end else begin
            irq_st_r <= irq_st_nxt;
            irq <= |(irq_st_nxt & irq_mask_r);
            if (wr_go && aw_addr_r == `BCL_A_CTRL) begin
                ctrl_r <= (ctrl_r & ~wr_mask[2:0]) | (w_data_r[2:0] & wr_mask[2:0]);
            end
            if (wr_go && aw_addr_r == `BCL_A_MASK) begin
                irq_mask_r <= (irq_mask_r & ~wr_mask[`BCL_NEV-1:0])
                    | (w_data_r[`BCL_NEV-1:0] & wr_mask[`BCL_NEV-1:0]);
            end
        end
    end

    // The reset controller holds the PLL down in reset and on request.
    always @(posedge core_clk) begin
        if (reset) begin
            tx_pll_powerdown <= 1'b1;
        end else begin
            tx_pll_powerdown <= ctrl_r[`BCL_CTRL_PD];
        end
    end

    // Lane words pass with one register stage each way.
    // Transmit words are dropped, not stalled, while the PLL is not ready.
    always @(posedge core_clk) begin
        if (reset) begin
            tx_pma_data <= 268'h0;
            tx_data_valid <= 4'h0;
            alignment_marker_valid <= 1'b0;
            rx_user_data <= 268'h0;
            rx_user_valid <= 4'h0;
        end else begin
            tx_pma_data <= tx_user_data;
            tx_data_valid <= tx_user_valid & {`BCL_LANES{tx_go}};
            alignment_marker_valid <= tx_user_am & tx_go;
            rx_user_data <= rx_pma_data;
            rx_user_valid <= rx_data_valid;
        end
    end

    always @* begin
        rd_val = 32'h0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `BCL_A_CTRL: rd_val[2:0] = ctrl_r;
            `BCL_A_STAT: rd_val = {sclk_alive_r, 12'h000, pll_s2_r, dec_enh,
                ceil_code_r, short_code_r, floor_code_r};
            `BCL_A_SIZE: rd_val = {6'h0, dec_seg, 6'h0, dec_ceil};
            `BCL_A_IRQ: rd_val[`BCL_NEV-1:0] = irq_st_r;
            `BCL_A_MASK: rd_val[`BCL_NEV-1:0] = irq_mask_r;
            default: rd_hit = 1'b0;
        endcase
    end

    // AXI4-Lite write side: address and data taken in either order.
    always @(posedge core_clk) begin
        if (reset) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `BCL_RESP_OK;
            aw_hold_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_hold_r <= 1'b0;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `BCL_RESP_OK : `BCL_RESP_ERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // AXI4-Lite read side: one read at a time, answered one cycle later.
    always @(posedge core_clk) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `BCL_RESP_OK;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_hit ? `BCL_RESP_OK : `BCL_RESP_ERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // bcl_top

// file: bcl_defines.vh
/*
 * Constants of the burst configuration and link side-band block.
 * Assumes one core clock of 40 MHz and byte addresses on an AXI4-Lite bus.
 */
`ifndef BCL_DEFINES_VH
`define BCL_DEFINES_VH

`define BCL_LANES 4
`define BCL_WORD 67

`define BCL_CEIL_128 4'h5
`define BCL_CEIL_256 4'h8
`define BCL_CEIL_512 4'h9
`define BCL_SZ_32 4'h1
`define BCL_SZ_64 4'h2
`define BCL_SZ_128 4'h4
`define BCL_FLOOR_OFF 4'h0

`define BCL_RST_CEIL 4'h8
`define BCL_RST_SHORT 4'h2
`define BCL_RST_FLOOR 4'h0

`define BCL_A_CTRL 8'h00
`define BCL_A_STAT 8'h04
`define BCL_A_SIZE 8'h08
`define BCL_A_IRQ 8'h0c
`define BCL_A_MASK 8'h10

`define BCL_CTRL_PD 0
`define BCL_CTRL_TXEN 1
`define BCL_CTRL_CLR 2
`define BCL_RST_CTRL 3'h2

`define BCL_EV_TXCOR 0
`define BCL_EV_TXUNC 1
`define BCL_EV_RXCOR 2
`define BCL_EV_RXUNC 3
`define BCL_EV_BADCFG 4
`define BCL_EV_UNLOCK 5
`define BCL_EV_XCERR 6
`define BCL_NEV 7

`define BCL_RESP_OK 2'h0
`define BCL_RESP_ERR 2'h2

`endif

// file: bcl_burst_dec.v
/*
 * Decoder of the burst size codes into byte counts and a validity flag.
 * Assumes stable codes from registers on the same clock.
 */
`include "bcl_defines.vh"

module bcl_burst_dec (
    // Codes
    input wire [3:0] ceil_code,
    input wire [3:0] short_code,
    input wire [3:0] floor_code,
    // Decoded values
    output reg [9:0] ceil_bytes,
    output reg [9:0] seg_bytes,
    output reg enh_en,
    output reg cfg_ok
);

    function [9:0] small_bytes;
        input [3:0] code;
        begin
            case (code)
                `BCL_SZ_32: small_bytes = 10'h020;
                `BCL_SZ_64: small_bytes = 10'h040;
                `BCL_SZ_128: small_bytes = 10'h080;
                default: small_bytes = 10'h000;
            endcase
        end
    endfunction

    reg [9:0] short_b;
    reg [9:0] floor_b;

    always @* begin
        case (ceil_code)
            `BCL_CEIL_128: ceil_bytes = 10'h080;
            `BCL_CEIL_256: ceil_bytes = 10'h100;
            `BCL_CEIL_512: ceil_bytes = 10'h200;
            default: ceil_bytes = 10'h000;
        endcase
        short_b = small_bytes(short_code);
        if (short_code == `BCL_SZ_128) begin
            short_b = 10'h000;
        end
        floor_b = small_bytes(floor_code);
        enh_en = (floor_code != `BCL_FLOOR_OFF);
        // A floor in effect replaces the short size for segmentation.
        seg_bytes = enh_en ? floor_b : short_b;
        cfg_ok = (ceil_bytes != 10'h000) && (short_b != 10'h000)
            && (!enh_en || (floor_b != 10'h000))
            && (!enh_en || ({floor_b, 1'b0} <= {1'b0, ceil_bytes}));
    end

endmodule // bcl_burst_dec

// file: bcl_link_model.sv
/*
 * Partner model: external transmit PLL and the transceiver channel.
 * Assumes it shares core_clk with the block and loops the transmit words back.
 */
module bcl_link_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Bench control
    input wire logic inject_err,
    // PLL side band
    input wire logic tx_pll_powerdown,
    output logic tx_pll_locked,
    output logic tx_pll_cal_busy,
    output logic [3:0] tx_serial_clk,
    output logic mac_pll_locked,
    // Lane words
    input wire logic [267:0] tx_pma_data,
    input wire logic [3:0] tx_data_valid,
    output logic [267:0] rx_pma_data,
    output logic [3:0] rx_data_valid,
    output logic xcoder_err
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] lock_cnt_r;
    always @(posedge core_clk) begin
        if (reset || tx_pll_powerdown) begin
            lock_cnt_r <= 5'h0;
        end else if (lock_cnt_r != 5'h10) begin
            lock_cnt_r <= lock_cnt_r + 5'h1;
        end
        // Calibration busy ends before lock rises.
        tx_pll_cal_busy <= !tx_pll_powerdown && lock_cnt_r < 5'h8;
        tx_pll_locked <= lock_cnt_r == 5'h10;
        mac_pll_locked <= lock_cnt_r == 5'h10;
        // Serial clocks stand still while the PLL is unlocked.
        tx_serial_clk <= (tx_pll_locked === 1'b1) ? ~tx_serial_clk : 4'h0;
        rx_data_valid <= reset ? 4'h0 : tx_data_valid;
        // With no lane valid, the received words flip to their own inverse each cycle.
        if (reset) begin
            rx_pma_data <= 268'h0;
        end else begin
            rx_pma_data <= |tx_data_valid ? tx_pma_data : ~rx_pma_data;
        end
        xcoder_err <= inject_err;
    end
endmodule // bcl_link_model

// file: bcl_top_chk.sv
/*
 * Port checker of bcl_top, bound to every instance.
 * Assumes one clock domain with a synchronous active high reset.
 */
module bcl_top_chk (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    // Lane words
    input wire logic [267:0] tx_user_data,
    input wire logic [3:0] tx_user_valid,
    input wire logic [267:0] tx_pma_data,
    input wire logic [3:0] tx_data_valid,
    input wire logic tx_pll_powerdown,
    input wire logic [3:0] rx_data_valid,
    input wire logic [3:0] rx_user_valid,
    // Status and sizes
    input wire logic [1:0] tx_mem_ecc,
    input wire logic [1:0] rx_mem_ecc,
    input wire logic [1:0] tx_ecc_status,
    input wire logic [1:0] rx_ecc_status,
    input wire logic [9:0] ceil_bytes,
    input wire logic [9:0] seg_bytes,
    input wire logic enh_sched_en
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    a_tx_ecc_level: assert property (!$past(reset) |-> tx_ecc_status == $past(tx_mem_ecc))
        else $error("tx ecc status wrong");
    a_rx_ecc_level: assert property (!$past(reset) |-> rx_ecc_status == $past(rx_mem_ecc))
        else $error("rx ecc status wrong");
    a_tx_word_pass: assert property (!$past(reset) |-> tx_pma_data == $past(tx_user_data))
        else $error("tx word not passed");
    a_tx_valid_src: assert property (!$past(reset) |->
        tx_data_valid == 4'h0 || tx_data_valid == $past(tx_user_valid))
        else $error("tx valid wrong");
    a_rx_valid_pass: assert property (!$past(reset) |-> rx_user_valid == $past(rx_data_valid))
        else $error("rx valid not passed");
    a_pd_gates_tx: assert property (tx_pll_powerdown [*2] |-> tx_data_valid == 4'h0)
        else $error("tx valid in power down");
    a_ceil_legal: assert property (!$past(reset) |-> ceil_bytes inside {10'd128, 10'd256, 10'd512})
        else $error("bad ceiling");
    a_seg_by_mode: assert property (!$past(reset) |-> (enh_sched_en ?
        seg_bytes inside {10'd32, 10'd64, 10'd128} : seg_bytes inside {10'd32, 10'd64}))
        else $error("bad segment size");
    a_size_hold_busy: assert property ((tx_user_valid != 4'h0) [*5] |->
        $stable(ceil_bytes) && $stable(seg_bytes) && $stable(enh_sched_en))
        else $error("sizes changed in traffic");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken before response");
endmodule // bcl_top_chk

bind bcl_top bcl_top_chk bcl_top_chk_inst (
    .core_clk(core_clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .tx_user_data(tx_user_data), .tx_user_valid(tx_user_valid),
    .tx_pma_data(tx_pma_data), .tx_data_valid(tx_data_valid),
    .tx_pll_powerdown(tx_pll_powerdown), .rx_data_valid(rx_data_valid),
    .rx_user_valid(rx_user_valid), .tx_mem_ecc(tx_mem_ecc), .rx_mem_ecc(rx_mem_ecc),
    .tx_ecc_status(tx_ecc_status), .rx_ecc_status(rx_ecc_status), .ceil_bytes(ceil_bytes),
    .seg_bytes(seg_bytes), .enh_sched_en(enh_sched_en)
);

// file: bcl_top_test.sv
/*
 * Self-checking bench of bcl_top with the link partner model.
 * Assumes one 40 MHz clock; the AXI4-Lite master is a pair of tasks.
 */
`include "bcl_defines.vh"
module bcl_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, tx_ecc_status, rx_ecc_status;
    logic [31:0] s_axi_rdata;
    logic [3:0] burst_size_ceiling = 4'h8, burst_size_short = 4'h2, burst_size_floor = 4'h0;
    logic [9:0] ceil_bytes, seg_bytes;
    logic enh_sched_en, tx_pll_locked, tx_pll_cal_busy, mac_pll_locked, tx_pll_powerdown;
    logic [1:0] tx_mem_ecc = 2'h0, rx_mem_ecc = 2'h0;
    logic [3:0] tx_serial_clk, tx_data_valid, rx_data_valid, rx_user_valid;
    logic [3:0] tx_user_valid = 4'h0;
    logic tx_user_am = 1'b0, inject_err = 1'b0, alignment_marker_valid, xcoder_err;
    logic [267:0] tx_pma_data, rx_pma_data, rx_user_data;
    logic [267:0] tx_user_data = {67'h4_0000_0000_0000_0003, 67'h2_5555_5555_5555_5502,
        67'h1_aaaa_aaaa_aaaa_aa01, 67'h3_1234_5678_9abc_de00};
    // Ceiling, short, floor; sets 5 and 6 refused; four-word user width.
    logic [11:0] cfg [8] = '{12'h510, 12'h821, 12'h812, 12'h824, 12'h924, 12'h524, 12'h840,
        12'h820};
    int exp_c [8] = '{128, 256, 256, 256, 512, 512, 512, 256};
    int exp_s [8] = '{32, 32, 64, 128, 128, 128, 128, 64};
    logic [7:0] exp_e = 8'h7e;
    int error_cnt = 0, checks_done = 0, cyc = 0;

    bcl_top bcl_top_inst (
        .core_clk(core_clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .irq(irq), .burst_size_ceiling(burst_size_ceiling),
        .burst_size_short(burst_size_short), .burst_size_floor(burst_size_floor),
        .ceil_bytes(ceil_bytes), .seg_bytes(seg_bytes), .enh_sched_en(enh_sched_en),
        .tx_mem_ecc(tx_mem_ecc), .rx_mem_ecc(rx_mem_ecc), .tx_ecc_status(tx_ecc_status),
        .rx_ecc_status(rx_ecc_status), .tx_pll_locked(tx_pll_locked),
        .tx_pll_cal_busy(tx_pll_cal_busy), .tx_serial_clk(tx_serial_clk),
        .mac_pll_locked(mac_pll_locked), .tx_pll_powerdown(tx_pll_powerdown),
        .tx_user_data(tx_user_data), .tx_user_valid(tx_user_valid), .tx_user_am(tx_user_am),
        .tx_pma_data(tx_pma_data), .tx_data_valid(tx_data_valid),
        .alignment_marker_valid(alignment_marker_valid), .rx_pma_data(rx_pma_data),
        .rx_data_valid(rx_data_valid), .xcoder_err(xcoder_err), .rx_user_data(rx_user_data),
        .rx_user_valid(rx_user_valid)
    );
    bcl_link_model bcl_link_model_inst (
        .core_clk(core_clk), .reset(reset), .inject_err(inject_err),
        .tx_pll_powerdown(tx_pll_powerdown), .tx_pll_locked(tx_pll_locked),
        .tx_pll_cal_busy(tx_pll_cal_busy), .tx_serial_clk(tx_serial_clk),
        .mac_pll_locked(mac_pll_locked), .tx_pma_data(tx_pma_data),
        .tx_data_valid(tx_data_valid), .rx_pma_data(rx_pma_data),
        .rx_data_valid(rx_data_valid), .xcoder_err(xcoder_err)
    );

    always #12.5 core_clk = ~core_clk;

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // About 200 cycles are needed; a hung handshake ends here.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, er, "bresp");
        @(posedge core_clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
        input logic [1:0] er);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata & m, exp, "rdata");
        check(s_axi_rresp, er, "rresp");
        @(posedge core_clk);
    endtask

    initial begin
        tick(20);
        reset <= 1'b0;
        tick(3);
        check(ceil_bytes, 10'd256, "ceil rst");
        check(seg_bytes, 10'd64, "seg rst");
        check(enh_sched_en, 1'b0, "enh rst");
        rd_chk(`BCL_A_CTRL, 32'h2, '1, `BCL_RESP_OK);
        rd_chk(`BCL_A_SIZE, {16'd64, 16'd256}, '1, `BCL_RESP_OK);
        rd_chk(8'h40, 32'h0, '1, `BCL_RESP_ERR);
        wr(8'h40, 32'h1, `BCL_RESP_ERR);
        $display("Test 1 done");
        for (int i = 0; i < 8; i++) begin
            {burst_size_ceiling, burst_size_short, burst_size_floor} <= cfg[i];
            tick(8);
            check(ceil_bytes, exp_c[i], "ceiling");
            check(seg_bytes, exp_s[i], "segment");
            check(enh_sched_en, exp_e[i], "enhanced");
        end
        $display("Test 2 done");
        tx_user_valid <= 4'hf;
        tx_user_am <= 1'b1;
        burst_size_ceiling <= `BCL_CEIL_128;
        tick(8);
        check(ceil_bytes, 10'd256, "ceil busy");
        check(tx_data_valid, 4'hf, "tx valid");
        check(alignment_marker_valid, 1'b1, "marker valid");
        check(tx_pma_data === tx_user_data, 1'b1, "tx words");
        check(rx_user_valid, 4'hf, "rx valid");
        check(rx_user_data === tx_user_data, 1'b1, "rx words");
        tx_user_valid <= 4'h0;
        tx_user_am <= 1'b0;
        tick(8);
        check(ceil_bytes, 10'd128, "ceil idle");
        $display("Test 3 done");
        tx_mem_ecc <= 2'b10;
        rx_mem_ecc <= 2'b01;
        tick(2);
        check(tx_ecc_status, 2'b10, "tx ecc");
        check(rx_ecc_status, 2'b01, "rx ecc");
        check(irq, 1'b0, "masked irq");
        rd_chk(`BCL_A_IRQ, 32'h19, '1, `BCL_RESP_OK);
        wr(`BCL_A_MASK, 32'hf, `BCL_RESP_OK);
        tick(2);
        check(irq, 1'b1, "unmasked irq");
        tx_mem_ecc <= 2'h0;
        rx_mem_ecc <= 2'h0;
        wr(`BCL_A_IRQ, 32'h7f, `BCL_RESP_OK);
        rd_chk(`BCL_A_IRQ, 32'h0, '1, `BCL_RESP_OK);
        check(irq, 1'b0, "cleared irq");
        $display("Test 4 done");
        tx_user_valid <= 4'hf;
        inject_err <= 1'b1;
        wr(`BCL_A_CTRL, 32'h3, `BCL_RESP_OK);
        inject_err <= 1'b0;
        tick(6);
        check(tx_pll_powerdown, 1'b1, "powerdown");
        check(tx_data_valid, 4'h0, "pd gate");
        rd_chk(`BCL_A_IRQ, 32'h60, 32'h60, `BCL_RESP_OK);
        wr(`BCL_A_CTRL, 32'h2, `BCL_RESP_OK);
        tick(30);
        check(tx_data_valid, 4'hf, "relock");
        rd_chk(`BCL_A_STAT, 32'hf000_a000, 32'hf000_e000, `BCL_RESP_OK);
        wr(`BCL_A_CTRL, 32'h0, `BCL_RESP_OK);
        tick(4);
        check(tx_data_valid, 4'h0, "tx off");
        tx_user_valid <= 4'h0;
        $display("Test 5 done");
        print_verdict();
    end
endmodule // bcl_top_test
